// ===== core/valve_command_shaper.sv
/*
 command shaping chain of a proportional valve amplifier: demand select,
 ramp, deadband, curve, current setpoint; classic wishbone registers.
 assumes inputs synchronous to clk and analogue commands as signed samples.
*/
// Design decisions made here: the register addresses and the Wishbone slave port.
module valve_command_shaper #(
   parameter int SAMPLE_CYC = vcs_pkg::SAMPLE_CYC
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronous reset
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte enables
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic enable, // enable input
   input wire logic selBit0, // preset select weight 1
   input wire logic selBit1, // preset select weight 2
   input wire logic selBit2, // preset select weight 4
   input wire logic dirPos, // direction positive
   input wire logic dirNeg, // direction negative
   input wire logic fastSel, // rapid speed
   input wire logic signed [15:0] cmdA, // analogue command a
   input wire logic signed [15:0] cmdB, // analogue command b
   input wire logic extErr, // external fault
   output logic ready, // ready output
   output logic irq, // interrupt level
   output logic [15:0] solA, // solenoid a setpoint ma
   output logic [15:0] solB, // solenoid b setpoint ma
   output logic [31:0] loopCfg // current loop settings
);
   function automatic logic [17:0] absv(input logic [17:0] v);
      absv = v[17] ? 18'(-v) : v;
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            o[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      merge = o;
   endfunction
   // -----------------------------------------------------------
   // register file
   // -----------------------------------------------------------
   logic [4:0] ctrl, next_ctrl;
   logic [15:0] rampUp, next_rampUp, rampDn, next_rampDn;
   logic [15:0] maxV, next_maxV, minV, next_minV, trig, next_trig;
   logic [15:0] nomMa, next_nomMa, slowScale, next_slowScale;
   logic [31:0] next_loopCfg, next_dat;
   logic [2:0] status, next_status, irqEn, next_irqEn, ev;
   logic next_ack, next_irq, acc, wr;
   logic errLatch, next_errLatch;
   vcs_pkg::preset_t presets [8], next_presets [8];
   vcs_pkg::point_t curve [2][vcs_pkg::NPTS], next_curve [2][vcs_pkg::NPTS];
   logic [15:0] next_solA, next_solB;
   logic [2:0] idx;
   assign idx = {selBit2, selBit1, selBit0};
   always_comb begin
      acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr = acc & wb_we_i;
      next_ack = acc;
      next_dat = wb_dat_o;
      next_ctrl = ctrl;
      next_rampUp = rampUp;
      next_rampDn = rampDn;
      next_maxV = maxV;
      next_minV = minV;
      next_trig = trig;
      next_nomMa = nomMa;
      next_loopCfg = loopCfg;
      next_slowScale = slowScale;
      next_irqEn = irqEn;
      next_presets = presets;
      next_curve = curve;
      // set wins over a clear in the same cycle
      next_status = status | ev;
      if (acc) begin
         next_dat = 32'h00000000;
         case (wb_adr_i)
            vcs_pkg::A_CTRL: next_dat = {27'h0, ctrl};
            vcs_pkg::A_RAMPUP: next_dat = {16'h0, rampUp};
            vcs_pkg::A_RAMPDN: next_dat = {16'h0, rampDn};
            vcs_pkg::A_MAXV: next_dat = {16'h0, maxV};
            vcs_pkg::A_MINV: next_dat = {16'h0, minV};
            vcs_pkg::A_TRIG: next_dat = {16'h0, trig};
            vcs_pkg::A_NOM: next_dat = {16'h0, nomMa};
            vcs_pkg::A_LOOP: next_dat = loopCfg;
            vcs_pkg::A_SLOW: next_dat = {16'h0, slowScale};
            vcs_pkg::A_STAT: next_dat = {29'h0, status};
            vcs_pkg::A_IRQEN: next_dat = {29'h0, irqEn};
            vcs_pkg::A_STATE: next_dat = {solB, 11'h0, idx, errLatch, ready};
            default: begin
               if (wb_adr_i[7:5] == {vcs_pkg::B_PRESET, 1'b0}) begin
                  next_dat = presets[wb_adr_i[4:2]];
               end else if (wb_adr_i[7] && wb_adr_i[5:2] < 4'(vcs_pkg::NPTS)) begin
                  next_dat = curve[wb_adr_i[6]][wb_adr_i[5:2]];
               end
            end
         endcase
      end
      if (wr) begin
         case (wb_adr_i)
            vcs_pkg::A_CTRL: next_ctrl = 5'(merge({27'h0, ctrl}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_RAMPUP: next_rampUp = 16'(merge({16'h0, rampUp}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_RAMPDN: next_rampDn = 16'(merge({16'h0, rampDn}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_MAXV: next_maxV = 16'(merge({16'h0, maxV}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_MINV: next_minV = 16'(merge({16'h0, minV}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_TRIG: next_trig = 16'(merge({16'h0, trig}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_NOM: next_nomMa = 16'(merge({16'h0, nomMa}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_LOOP: next_loopCfg = merge(loopCfg, wb_dat_i, wb_sel_i);
            vcs_pkg::A_SLOW: next_slowScale = 16'(merge({16'h0, slowScale}, wb_dat_i, wb_sel_i));
            vcs_pkg::A_CLR: next_status = (status & ~wb_dat_i[2:0]) | ev;
            vcs_pkg::A_IRQEN: next_irqEn = 3'(merge({29'h0, irqEn}, wb_dat_i, wb_sel_i));
            default: begin
               if (wb_adr_i[7:5] == {vcs_pkg::B_PRESET, 1'b0}) begin
                  next_presets[wb_adr_i[4:2]] = merge(presets[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
               end else if (wb_adr_i[7] && wb_adr_i[5:2] < 4'(vcs_pkg::NPTS)) begin
                  next_curve[wb_adr_i[6]][wb_adr_i[5:2]] =
                     merge(curve[wb_adr_i[6]][wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
               end
            end
         endcase
      end
      next_irq = |(next_status & next_irqEn);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= vcs_pkg::RST_CTRL;
         rampUp <= 16'h0000;
         rampDn <= 16'h0000;
         maxV <= vcs_pkg::RST_MAXV;
         minV <= 16'h0000;
         trig <= 16'h0000;
         nomMa <= vcs_pkg::MAX_MA;
         loopCfg <= 32'h00000000;
         slowScale <= vcs_pkg::RST_SLOW;
         status <= 3'h0;
         irqEn <= 3'h0;
         presets <= '{default: 32'h00000000};
         curve <= '{default: '{default: 32'h00000000}};
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         rampUp <= next_rampUp;
         rampDn <= next_rampDn;
         maxV <= next_maxV;
         minV <= next_minV;
         trig <= next_trig;
         nomMa <= next_nomMa;
         loopCfg <= next_loopCfg;
         slowScale <= next_slowScale;
         status <= next_status;
         irqEn <= next_irqEn;
         presets <= next_presets;
         curve <= next_curve;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         irq <= next_irq;
      end
   end
   // -----------------------------------------------------------
   // sample pipeline
   // -----------------------------------------------------------
   vcs_pkg::state_t st, next_st;
   vcs_pkg::fn_t mode;
   logic [17:0] tickCnt, next_tickCnt, cur [2], next_cur [2], tgt, next_tgt, t, m, step, sh, dx;
   logic [17:0] base, next_base, fin;
   logic [32:0] divRem, next_divRem, rem2;
   logic [31:0] divQuo, next_divQuo;
   logic [15:0] divDen, next_divDen, rampT;
   logic [5:0] divCnt, next_divCnt;
   logic chan, next_chan, divPh, next_divPh, outNeg, next_outNeg, baseNeg, next_baseNeg;
   logic run, tick, rising, hit;
   logic [35:0] prod;
   vcs_pkg::point_t lo, hi;
   assign mode = vcs_pkg::fn_t'(ctrl[1:0]);
   always_comb begin
      next_st = st;
      next_chan = chan;
      next_cur = cur;
      next_tgt = tgt;
      next_base = base;
      next_baseNeg = baseNeg;
      next_outNeg = outNeg;
      next_divRem = divRem;
      next_divQuo = divQuo;
      next_divDen = divDen;
      next_divCnt = divCnt;
      next_divPh = divPh;
      next_solA = solA;
      next_solB = solB;
      ev = 3'h0;
      tick = tickCnt == 18'(SAMPLE_CYC - 1);
      next_tickCnt = tick ? 18'h0 : 18'(tickCnt + 18'h1);
      ev[vcs_pkg::ST_ERR] = extErr | (mode != vcs_pkg::FN_PRESET &&
         (absv(18'(cmdA)) > vcs_pkg::FS || absv(18'(cmdB)) > vcs_pkg::FS));
      next_errLatch = (errLatch & enable) | ev[vcs_pkg::ST_ERR];
      run = enable & ~errLatch;
      m = fastSel ? absv(18'(cmdA)) : 18'((34'(absv(18'(cmdA))) * slowScale) >> vcs_pkg::FS_SH);
      case (mode)
         vcs_pkg::FN_PRESET: t = 18'(presets[idx].value);
         vcs_pkg::FN_DUAL: t = (chan ? cmdB[15] : cmdA[15]) ? 18'h0 : 18'(chan ? cmdB : cmdA);
         default: t = !ctrl[vcs_pkg::C_DIR] ? 18'(cmdA) : (dirPos & ~dirNeg) ? m : (dirNeg & ~dirPos) ? 18'(-m) : 18'h0;
      endcase
      if (absv(t) > vcs_pkg::FS) begin
         t = t[17] ? 18'(-vcs_pkg::FS) : vcs_pkg::FS;
      end
      rising = absv(t) > absv(cur[chan]);
      rampT = (mode == vcs_pkg::FN_PRESET && ctrl[vcs_pkg::C_RS]) ? presets[idx].rampMs : rising ? rampUp : rampDn;
      rem2 = {divRem[31:0], divQuo[31]};
      step = divQuo > 32'(vcs_pkg::FS) ? vcs_pkg::FS : divQuo[17:0];
      sh = absv(cur[chan]);
      if (sh < 18'(trig)) begin
         sh = 18'h0;
      end else begin
         prod = 36'(sh) * (maxV > minV ? 36'(maxV - minV) : 36'h0);
         sh = 18'(minV) + 18'(prod >> vcs_pkg::FS_SH);
         sh = sh > 18'(maxV) ? 18'(maxV) : sh;
      end
      lo = 32'h0;
      hi = 32'h0;
      hit = 1'b0;
      for (int i = 0; i < vcs_pkg::NPTS; i++) begin
         if (!hit && sh < 18'(curve[cur[chan][17]][i].x)) begin
            hit = 1'b1;
            hi = curve[cur[chan][17]][i];
         end else if (!hit) begin
            lo = curve[cur[chan][17]][i];
         end
      end
      dx = 18'(hi.x) - 18'(lo.x);
      fin = baseNeg ? 18'(base - divQuo[17:0]) : 18'(base + divQuo[17:0]);
      fin = (baseNeg && divQuo[17:0] > base) ? 18'h0 : fin;
      prod = (36'(fin) * nomMa) >> vcs_pkg::FS_SH;
      case (st)
         vcs_pkg::S_IDLE: begin
            if (tick && run) begin
               next_st = vcs_pkg::S_PREP;
               next_chan = 1'b0;
            end
         end
         vcs_pkg::S_PREP: begin
            next_tgt = t;
            next_divPh = 1'b0;
            next_divQuo = 32'(vcs_pkg::FS);
            next_divRem = 33'h0;
            next_divDen = rampT;
            next_divCnt = 6'h20;
            next_st = rampT == 16'h0 ? vcs_pkg::S_SLEW : vcs_pkg::S_DIV;
         end
         vcs_pkg::S_DIV: begin
            next_divRem = rem2 >= 33'(divDen) ? 33'(rem2 - 33'(divDen)) : rem2;
            next_divQuo = {divQuo[30:0], rem2 >= 33'(divDen)};
            next_divCnt = 6'(divCnt - 6'h1);
            if (divCnt == 6'h1) begin
               next_st = divPh ? vcs_pkg::S_OUT : vcs_pkg::S_SLEW;
            end
         end
         vcs_pkg::S_SLEW: begin
            if ($signed(tgt) > $signed(cur[chan])) begin
               next_cur[chan] = ($signed(tgt) - $signed(cur[chan]) > $signed(step)) ? 18'(cur[chan] + step) : tgt;
            end else begin
               next_cur[chan] = ($signed(cur[chan]) - $signed(tgt) > $signed(step)) ? 18'(cur[chan] - step) : tgt;
            end
            ev[vcs_pkg::ST_REACH] = next_cur[chan] == tgt && cur[chan] != tgt;
            next_st = vcs_pkg::S_SHAPE;
         end
         vcs_pkg::S_SHAPE: begin
            next_outNeg = cur[chan][17];
            next_base = sh;
            next_baseNeg = 1'b0;
            next_divQuo = 32'h0;
            next_st = vcs_pkg::S_OUT;
            if (ctrl[vcs_pkg::C_CURVE]) begin
               next_base = hit ? 18'(lo.y) : 18'(lo.y);
               if (hit) begin
                  next_baseNeg = hi.y < lo.y;
                  next_divQuo = 32'(sh - 18'(lo.x)) * 32'(hi.y < lo.y ? lo.y - hi.y : hi.y - lo.y);
                  next_divRem = 33'h0;
                  next_divDen = 16'(dx);
                  next_divCnt = 6'h20;
                  next_divPh = 1'b1;
                  next_st = vcs_pkg::S_DIV;
               end
            end
         end
         vcs_pkg::S_OUT: begin
            m = prod > 36'(vcs_pkg::MAX_MA) ? 18'(vcs_pkg::MAX_MA) : 18'(prod);
            // dual mode keeps one quadrant per channel
            if (mode == vcs_pkg::FN_DUAL) begin
               if (chan) next_solB = 16'(m);
               else next_solA = 16'(m);
            end else begin
               next_solA = outNeg ? 16'h0 : 16'(m);
               next_solB = outNeg ? 16'(m) : 16'h0;
            end
            next_chan = ~chan;
            next_st = (mode == vcs_pkg::FN_DUAL && !chan) ? vcs_pkg::S_PREP : vcs_pkg::S_IDLE;
            ev[vcs_pkg::ST_SAMPLE] = !(mode == vcs_pkg::FN_DUAL && !chan);
         end
         default: next_st = vcs_pkg::S_IDLE;
      endcase
      if (!run) begin
         next_st = vcs_pkg::S_IDLE;
         next_cur = '{default: 18'h0};
         next_solA = 16'h0;
         next_solB = 16'h0;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= vcs_pkg::S_IDLE;
         chan <= 1'b0;
         cur <= '{default: 18'h0};
         tgt <= 18'h0;
         base <= 18'h0;
         baseNeg <= 1'b0;
         outNeg <= 1'b0;
         divRem <= 33'h0;
         divQuo <= 32'h0;
         divDen <= 16'h0;
         divCnt <= 6'h0;
         divPh <= 1'b0;
         tickCnt <= 18'h0;
         errLatch <= 1'b0;
         ready <= 1'b0;
         solA <= 16'h0;
         solB <= 16'h0;
      end else begin
         st <= next_st;
         chan <= next_chan;
         cur <= next_cur;
         tgt <= next_tgt;
         base <= next_base;
         baseNeg <= next_baseNeg;
         outNeg <= next_outNeg;
         divRem <= next_divRem;
         divQuo <= next_divQuo;
         divDen <= next_divDen;
         divCnt <= next_divCnt;
         divPh <= next_divPh;
         tickCnt <= next_tickCnt;
         errLatch <= next_errLatch;
         ready <= enable & ~next_errLatch;
         solA <= next_solA;
         solB <= next_solB;
      end
   end
   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   property p_ack_once;
      @(posedge clk) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   property p_ack_next;
      @(posedge clk) disable iff (!rst_n) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack");
   property p_rdy_en;
      @(posedge clk) disable iff (!rst_n) !enable |=> !ready && solA == 16'h0 && solB == 16'h0;
   endproperty
   a_rdy_en: assert property (p_rdy_en) else $error("active while disabled");
   property p_rdy_err;
      @(posedge clk) disable iff (!rst_n) extErr |=> !ready ##1 (solA == 16'h0 && solB == 16'h0);
   endproperty
   a_rdy_err: assert property (p_rdy_err) else $error("ready during fault");
   property p_lim;
      @(posedge clk) disable iff (!rst_n) solA <= vcs_pkg::MAX_MA && solB <= vcs_pkg::MAX_MA;
   endproperty
   a_lim: assert property (p_lim) else $error("current over limit");
   property p_side;
      @(posedge clk) disable iff (!rst_n) mode != vcs_pkg::FN_DUAL [*2] |-> (solA == 16'h0 || solB == 16'h0);
   endproperty
   a_side: assert property (p_side) else $error("both solenoids driven");
   property p_irq;
      @(posedge clk) disable iff (!rst_n) irqEn == 3'h0 [*2] |-> !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("masked interrupt");
   property p_dead;
      @(posedge clk) disable iff (!rst_n)
         (st == vcs_pkg::S_SHAPE && absv(cur[chan]) < 18'(trig) && !ctrl[vcs_pkg::C_CURVE]) |=> base == 18'h0;
   endproperty
   a_dead: assert property (p_dead) else $error("deadband leaks");
   property p_slew;
      // a stop or fault zeroes the ramp on purpose, so only a running slew is bounded
      @(posedge clk) disable iff (!rst_n)
         (st == vcs_pkg::S_SLEW && run) |=> absv(18'(cur[$past(chan)] - $past(cur[chan]))) <= $past(step);
   endproperty
   a_slew: assert property (p_slew) else $error("ramp step too large");
   c_sample: cover property (@(posedge clk) disable iff (!rst_n) ev[vcs_pkg::ST_SAMPLE] && solA != 16'h0);
   c_neg: cover property (@(posedge clk) disable iff (!rst_n) solB != 16'h0 && mode == vcs_pkg::FN_PRESET);
   c_curve: cover property (@(posedge clk) disable iff (!rst_n) st == vcs_pkg::S_DIV && divPh);
   c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
endmodule

// ===== core/vcs_pkg.sv
/*
 constants, types and register map of the valve command shaper.
 assumes a 250 MHz system clock and a 1 ms control sample.
*/
package vcs_pkg;
   // -----------------------------------------------------------
   // timing
   // -----------------------------------------------------------
   localparam int CLK_NS = 4;
   localparam int SAMPLE_NS = 1000000;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
   // -----------------------------------------------------------
   // scaling: full scale command is 2^14
   // -----------------------------------------------------------
   localparam logic [17:0] FS = 18'h04000;
   localparam int FS_SH = 14;
   localparam logic [15:0] MAX_MA = 16'h0a28;
   // -----------------------------------------------------------
   // register byte addresses
   // -----------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_RAMPUP = 8'h04;
   localparam logic [7:0] A_RAMPDN = 8'h08;
   localparam logic [7:0] A_MAXV = 8'h0c;
   localparam logic [7:0] A_MINV = 8'h10;
   localparam logic [7:0] A_TRIG = 8'h14;
   localparam logic [7:0] A_NOM = 8'h18;
   localparam logic [7:0] A_LOOP = 8'h1c;
   localparam logic [7:0] A_SLOW = 8'h20;
   localparam logic [7:0] A_STAT = 8'h24;
   localparam logic [7:0] A_CLR = 8'h28;
   localparam logic [7:0] A_IRQEN = 8'h2c;
   localparam logic [7:0] A_STATE = 8'h30;
   localparam logic [1:0] B_PRESET = 2'h1;
   localparam logic [1:0] B_CURVE = 2'h2;
   localparam int NPTS = 10;
   // -----------------------------------------------------------
   // control fields and reset values
   // -----------------------------------------------------------
   localparam int C_RS = 2;
   localparam int C_CURVE = 3;
   localparam int C_DIR = 4;
   localparam logic [4:0] RST_CTRL = 5'h00;
   localparam logic [15:0] RST_MAXV = 16'h4000;
   localparam logic [15:0] RST_SLOW = 16'h2000;
   localparam int ST_SAMPLE = 0;
   localparam int ST_ERR = 1;
   localparam int ST_REACH = 2;
   typedef enum logic [1:0] {
      FN_SINGLE = 2'h0,
      FN_DUAL = 2'h1,
      FN_PRESET = 2'h2
   } fn_t;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_PREP = 6'h02,
      S_DIV = 6'h04,
      S_SLEW = 6'h08,
      S_SHAPE = 6'h10,
      S_OUT = 6'h20
   } state_t;
   typedef struct packed {
      logic [15:0] rampMs;
      logic signed [15:0] value;
   } preset_t;
   typedef struct packed {
      logic [15:0] y;
      logic [15:0] x;
   } point_t;
endpackage

// ===== test/valve_command_shaper_tb_top.sv
/*
 self-checking bench of the valve command shaper.
 assumes the core package, the shaper and the solenoid model.
*/
module valve_command_shaper_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // signals
   // ----
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, enable = 1'b0, extErr = 1'b0;
   logic s0 = 1'b0, s1 = 1'b0, s2 = 1'b0, dp = 1'b0, dn = 1'b0, fs = 1'b0, ack, ready, irq, over;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dato, loop;
   logic [3:0] sel = 4'hf;
   logic signed [15:0] cA = 16'h0, cB = 16'h0;
   logic [15:0] solA, solB;
   int mismatches = 0, n_tests = 0, cycles = 0;
   typedef struct packed {
      logic [4:0] ctrl;
      logic [15:0] maxv, minv, trig;
      logic [2:0] dpf;
      logic [15:0] ca, cb, ea, eb;
   } row_t;
   // ctrl, max, min, trigger, dirPos/dirNeg/fastSel, cmdA, cmdB, solA, solB
   row_t rows [10] = '{
      '{5'h00, 16'h4000, 16'h0, 16'h0, 3'h0, 16'h2000, 16'h0, 16'h0514, 16'h0},
      '{5'h00, 16'h4000, 16'h0, 16'h0, 3'h0, 16'he000, 16'h0, 16'h0, 16'h0514},
      '{5'h00, 16'h4000, 16'h0, 16'h1000, 3'h0, 16'h0800, 16'h0, 16'h0, 16'h0},
      '{5'h00, 16'h3000, 16'h1000, 16'h1000, 3'h0, 16'h2000, 16'h0, 16'h0514, 16'h0},
      '{5'h00, 16'h3000, 16'h1000, 16'h1000, 3'h0, 16'hc000, 16'h0, 16'h0, 16'h079e},
      '{5'h10, 16'h4000, 16'h0, 16'h0, 3'h4, 16'h4000, 16'h0, 16'h0514, 16'h0},
      '{5'h10, 16'h4000, 16'h0, 16'h0, 3'h3, 16'h4000, 16'h0, 16'h0, 16'h0a28},
      '{5'h01, 16'h4000, 16'h0, 16'h0, 3'h0, 16'h2000, 16'he000, 16'h0514, 16'h0},
      '{5'h08, 16'h4000, 16'h0, 16'h0, 3'h0, 16'h2000, 16'h0, 16'h028a, 16'h0},
      '{5'h08, 16'h4000, 16'h0, 16'h0, 3'h0, 16'he000, 16'h0, 16'h0, 16'h028a}
   };
   logic [39:0] regs [4] = '{{8'h0c, 32'h4000}, {8'h20, 32'h2000}, {8'h18, 32'h0a28}, {8'h34, 32'h0}};
   always #2 clk = ~clk;
   valve_command_shaper #(.SAMPLE_CYC(200)) dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
      .enable(enable), .selBit0(s0), .selBit1(s1), .selBit2(s2), .dirPos(dp), .dirNeg(dn), .fastSel(fs),
      .cmdA(cA), .cmdB(cB), .extErr(extErr), .ready(ready), .irq(irq), .solA(solA), .solB(solB), .loopCfg(loop));
   valve_solenoid_model coils (.clk(clk), .setA(solA), .setB(solB), .over(over));
   // ----
   // tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one classic cycle; read data is taken at the acking edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge clk);
      sel <= s;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // ----
   // sequence
   // ----
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      foreach (regs[i]) begin
         bus(1'b0, regs[i][39:32], 32'h0);
         check(rdat, regs[i][31:0], "regRead");
      end
      enable <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         bus(1'b1, 8'h80 + 8'(4 * i), {16'(i + 1) << 9, 16'(i + 1) << 10});
         bus(1'b1, 8'hc0 + 8'(4 * i), {16'(i + 1) << 9, 16'(i + 1) << 10});
      end
      foreach (rows[i]) begin
         bus(1'b1, vcs_pkg::A_CTRL, {27'h0, rows[i].ctrl});
         bus(1'b1, vcs_pkg::A_MAXV, {16'h0, rows[i].maxv});
         bus(1'b1, vcs_pkg::A_MINV, {16'h0, rows[i].minv});
         bus(1'b1, vcs_pkg::A_TRIG, {16'h0, rows[i].trig});
         {dp, dn, fs} <= rows[i].dpf;
         cA <= rows[i].ca;
         cB <= rows[i].cb;
         repeat (500) @(posedge clk);
         check({16'h0, solA}, {16'h0, rows[i].ea}, "solA");
         check({16'h0, solB}, {16'h0, rows[i].eb}, "solB");
      end
      bus(1'b1, vcs_pkg::A_CTRL, 32'h2);
      for (int i = 0; i < 8; i++) bus(1'b1, 8'h40 + 8'(4 * i), 32'(i) << 11);
      for (int i = 0; i < 8; i++) begin
         {s2, s1, s0} <= 3'(i);
         repeat (500) @(posedge clk);
         check({16'h0, solA}, 32'(i * 325), "preset");
      end
      // per-preset ramp: full step over four samples
      bus(1'b1, 8'h5c, 32'h0004_4000);
      bus(1'b1, vcs_pkg::A_CTRL, 32'h6);
      {s2, s1, s0} <= 3'h0;
      repeat (500) @(posedge clk);
      {s2, s1, s0} <= 3'h7;
      repeat (250) @(posedge clk);
      check({31'h0, solA < 16'h0a28}, 32'h1, "slewing");
      repeat (1000) @(posedge clk);
      check({16'h0, solA}, 32'h0a28, "slewEnd");
      bus(1'b1, vcs_pkg::A_IRQEN, 32'h2);
      check({30'h0, irq, ready}, 32'h1, "maskedIrq");
      extErr <= 1'b1;
      repeat (3) @(posedge clk);
      extErr <= 1'b0;
      repeat (3) @(posedge clk);
      check({30'h0, irq, ready}, 32'h2, "errLatch");
      bus(1'b1, vcs_pkg::A_CLR, 32'h2);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0, "irqClear");
      // sample-done and target-reached stay sticky, the error bit is gone
      bus(1'b0, vcs_pkg::A_STAT, 32'h0);
      check(rdat, 32'h5, "stickyStatus");
      enable <= 1'b0;
      repeat (3) @(posedge clk);
      check({15'h0, ready, solA}, 32'h0, "disabled");
      enable <= 1'b1;
      repeat (3) @(posedge clk);
      check({31'h0, ready}, 32'h1, "readyBack");
      check({31'h0, over}, 32'h0, "coilRating");
      // loop settings reach the power stage; byte enables merge
      bus(1'b1, vcs_pkg::A_LOOP, 32'h5a5a0c3c);
      check(loop, 32'h5a5a0c3c, "loopCfg");
      bus(1'b1, vcs_pkg::A_LOOP, 32'hffffffff, 4'h1);
      check(loop, 32'h5a5a0cff, "loopSel");
      // reset in mid-run
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check({14'h0, irq, ready, solA}, 32'h0, "resetOut");
      check(loop, 32'h0, "resetLoop");
      rst_n <= 1'b1;
      bus(1'b0, vcs_pkg::A_CTRL, 32'h0);
      check(rdat, 32'h0, "resetCtrl");
      report_and_stop();
   end
endmodule

// ===== test/valve_solenoid_model.sv
/*
 solenoid pair model: watches the current setpoints sent to the coils.
 assumes setpoints in mA on the shaper clock.
*/
module valve_solenoid_model (
   input wire logic clk, // clock
   input wire logic [15:0] setA, // setpoint a
   input wire logic [15:0] setB, // setpoint b
   output logic over // setpoint above coil rating
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen = 1'b0;
   assign over = seen;
   always @(posedge clk) begin
      seen <= seen | (setA > vcs_pkg::MAX_MA) | (setB > vcs_pkg::MAX_MA);
   end
endmodule
